// File: rtl/tcm_readout_top.sv
// thermocouple channel readout: scan rotation, input words, axi4-lite
`timescale 1ns/1ps
`include "tcm_map.svh"
module tcm_readout_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // controller scan strobe, asynchronous pin
   input wire logic scan_strobe,
   // converter side, same clock
   input wire logic conv_valid,
   input wire logic [2:0] conv_chan,
   input wire logic [15:0] conv_value,
   input wire logic conv_neg,
   input wire logic [7:0] conv_open,
   // discrete input points toward the controller
   output logic [15:0] data_word,
   output logic [15:0] status_word,
   output logic sign_flag_input,
   output logic [2:0] channel_index_inputs,
   output logic irq,
   // axi4-lite slave
   input wire logic [`TCM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`TCM_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   typedef struct packed {
      tcm_pkg::tcm_wr_e wr_st;
      logic aw_have;
      logic w_have;
      logic [`TCM_ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      tcm_pkg::tcm_rd_e rd_st;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] chan_en;
      logic [1:0] cfg;
      logic [8:0] status;
      logic [8:0] mask;
      logic irq;
      logic sync1;
      logic sync2;
      logic scan_prev;
      logic started;
      logic [2:0] idx;
      logic [15:0] lo_word;
      logic [15:0] hi_word;
      logic [15:0] scan_cnt;
   } tcm_top_s;

   tcm_top_s s_ff;
   tcm_top_s nxt_s;

   tcm_store_if sif();

   tcm_chan_store u_store (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .sif(sif)
   );

   // first enabled channel at or after start, bit 3 says found
   function automatic logic [3:0] find_from(
      logic [2:0] start,
      logic [7:0] en
   );
      logic [2:0] c;
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         c = start + 3'(i);
         if (en[c]) begin
            r = {1'b1, c};
         end
      end
      return r;
   endfunction

   // byte-lane merge of a write into an old register value
   function automatic logic [31:0] merge(
      logic [31:0] old,
      logic [31:0] wd,
      logic [3:0] strb
   );
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] reg_read(
      tcm_top_s s,
      logic [`TCM_ADDR_W-1:0] a
   );
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == `TCM_OFF_CHAN_EN) begin
         r[7:0] = s.chan_en;
      end else if (a == `TCM_OFF_CFG) begin
         r[1:0] = s.cfg;
      end else if (a == `TCM_OFF_STATUS) begin
         r[8:0] = s.status;
      end else if (a == `TCM_OFF_MASK) begin
         r[8:0] = s.mask;
      end else if (a == `TCM_OFF_PRESENT) begin
         r = {s.hi_word, s.lo_word};
      end else if (a == `TCM_OFF_SCAN_CNT) begin
         r[15:0] = s.scan_cnt;
      end
      return r;
   endfunction

   function automatic logic addr_ok(logic [`TCM_ADDR_W-1:0] a);
      return a == `TCM_OFF_CHAN_EN || a == `TCM_OFF_CFG ||
         a == `TCM_OFF_STATUS || a == `TCM_OFF_MASK ||
         a == `TCM_OFF_PRESENT || a == `TCM_OFF_SCAN_CNT;
   endfunction

   logic scan_edge;
   logic [3:0] pick;
   logic [31:0] wr_val;
   logic [8:0] st_set;
   logic [8:0] st_clr;

   assign scan_edge = s_ff.sync2 & ~s_ff.scan_prev;
   assign sif.conv_valid = conv_valid;
   assign sif.conv_chan = conv_chan;
   assign sif.conv_value = conv_value;
   assign sif.conv_neg = conv_neg;
   assign sif.conv_open = conv_open;
   assign sif.fmt_twos = s_ff.cfg[`TCM_CFG_TWOS];
   assign sif.fmt_unip = s_ff.cfg[`TCM_CFG_UNIP];
   assign sif.sel_chan = pick[2:0];

   // next channel in rotation, skipping disabled ones
   always_comb begin
      if (s_ff.started) begin
         pick = find_from(s_ff.idx + 3'h1, s_ff.chan_en);
      end else begin
         pick = find_from(3'h0, s_ff.chan_en);
      end
   end

   always_comb begin
      nxt_s = s_ff;
      wr_val = 32'h0000_0000;
      st_set = 9'h000;
      st_clr = 9'h000;

      // scan strobe synchroniser, second stage feeds the edge detector
      nxt_s.sync1 = scan_strobe;
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.scan_prev = s_ff.sync2;

      // write address and data taken in either order
      if (s_axi_awvalid && s_ff.awready) begin
         nxt_s.aw_have = 1'b1;
         nxt_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_ff.wready) begin
         nxt_s.w_have = 1'b1;
         nxt_s.wdata = s_axi_wdata;
         nxt_s.wstrb = s_axi_wstrb;
      end

      case (s_ff.wr_st)
         tcm_pkg::WR_IDLE: begin
            if (s_ff.aw_have && s_ff.w_have) begin
               nxt_s.aw_have = 1'b0;
               nxt_s.w_have = 1'b0;
               nxt_s.bvalid = 1'b1;
               nxt_s.wr_st = tcm_pkg::WR_RESP;
               nxt_s.bresp = addr_ok(s_ff.awaddr) ?
                  `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
               if (s_ff.awaddr == `TCM_OFF_CHAN_EN) begin
                  wr_val = merge({24'h00_0000, s_ff.chan_en},
                     s_ff.wdata, s_ff.wstrb);
                  nxt_s.chan_en = wr_val[7:0];
               end else if (s_ff.awaddr == `TCM_OFF_CFG) begin
                  wr_val = merge({30'h0000_0000, s_ff.cfg},
                     s_ff.wdata, s_ff.wstrb);
                  nxt_s.cfg = wr_val[1:0];
               end else if (s_ff.awaddr == `TCM_OFF_STATUS) begin
                  wr_val = merge(32'h0000_0000, s_ff.wdata, s_ff.wstrb);
                  st_clr = wr_val[8:0];
               end else if (s_ff.awaddr == `TCM_OFF_MASK) begin
                  wr_val = merge({23'h00_0000, s_ff.mask},
                     s_ff.wdata, s_ff.wstrb);
                  nxt_s.mask = wr_val[8:0];
               end
            end
         end
         tcm_pkg::WR_RESP: begin
            if (s_axi_bready) begin
               nxt_s.bvalid = 1'b0;
               nxt_s.wr_st = tcm_pkg::WR_IDLE;
            end
         end
         default: begin
            nxt_s.wr_st = tcm_pkg::WR_IDLE;
         end
      endcase
      nxt_s.awready = (nxt_s.wr_st == tcm_pkg::WR_IDLE) && !nxt_s.aw_have;
      nxt_s.wready = (nxt_s.wr_st == tcm_pkg::WR_IDLE) && !nxt_s.w_have;

      case (s_ff.rd_st)
         tcm_pkg::RD_IDLE: begin
            if (s_axi_arvalid) begin
               nxt_s.rdata = reg_read(s_ff, s_axi_araddr);
               nxt_s.rresp = addr_ok(s_axi_araddr) ?
                  `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
               nxt_s.rvalid = 1'b1;
               nxt_s.arready = 1'b0;
               nxt_s.rd_st = tcm_pkg::RD_RESP;
            end
         end
         tcm_pkg::RD_RESP: begin
            if (s_axi_rready) begin
               nxt_s.rvalid = 1'b0;
               nxt_s.arready = 1'b1;
               nxt_s.rd_st = tcm_pkg::RD_IDLE;
            end
         end
         default: begin
            nxt_s.rd_st = tcm_pkg::RD_IDLE;
         end
      endcase

      // one channel per scan; nothing enabled leaves the words frozen
      if (scan_edge && pick[3]) begin
         nxt_s.started = 1'b1;
         nxt_s.idx = pick[2:0];
         nxt_s.scan_cnt = s_ff.scan_cnt + 16'h0001;
         // all points reload in one edge, never a mixed sample
         nxt_s.lo_word = sif.sel_word;
         nxt_s.hi_word = {sif.open_flags,
            {`TCM_UNUSED_W{1'b0}},
            pick[2:0]};
         if (s_ff.started && pick[2:0] <= s_ff.idx) begin
            st_set[`TCM_ST_WRAP] = 1'b1;
         end
      end
      st_set[7:0] = sif.open_rise;

      // a new event outranks a clear in the same cycle
      nxt_s.status = (s_ff.status & ~st_clr) | st_set;
      nxt_s.irq = |(nxt_s.status & nxt_s.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
         s_ff.wr_st <= tcm_pkg::WR_IDLE;
         s_ff.rd_st <= tcm_pkg::RD_IDLE;
         s_ff.awready <= 1'b1;
         s_ff.wready <= 1'b1;
         s_ff.arready <= 1'b1;
         s_ff.chan_en <= `TCM_RST_CHAN_EN;
         s_ff.cfg <= `TCM_RST_CFG;
         s_ff.status <= `TCM_RST_STATUS;
         s_ff.mask <= `TCM_RST_MASK;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   assign data_word = s_ff.lo_word;
   assign status_word = s_ff.hi_word;
   assign sign_flag_input = s_ff.lo_word[`TCM_SIGN_BIT];
   assign channel_index_inputs = s_ff.hi_word[2:0];
   assign irq = s_ff.irq;
   assign s_axi_awready = s_ff.awready;
   assign s_axi_wready = s_ff.wready;
   assign s_axi_bresp = s_ff.bresp;
   assign s_axi_bvalid = s_ff.bvalid;
   assign s_axi_arready = s_ff.arready;
   assign s_axi_rdata = s_ff.rdata;
   assign s_axi_rresp = s_ff.rresp;
   assign s_axi_rvalid = s_ff.rvalid;

endmodule

// File: common/tcm_map.svh
// register map, field positions and reset values of the readout block
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

`define TCM_ADDR_W 8
`define TCM_NCH 8
`define TCM_OFF_CHAN_EN 8'h00
`define TCM_OFF_CFG 8'h04
`define TCM_OFF_STATUS 8'h08
`define TCM_OFF_MASK 8'h0c
`define TCM_OFF_PRESENT 8'h10
`define TCM_OFF_SCAN_CNT 8'h14

`define TCM_RST_CHAN_EN 8'hff
`define TCM_RST_CFG 2'h0
`define TCM_RST_STATUS 9'h000
`define TCM_RST_MASK 9'h000

`define TCM_CFG_TWOS 0
`define TCM_CFG_UNIP 1
`define TCM_ST_WRAP 8
`define TCM_SIGN_BIT 15
`define TCM_UNUSED_W 5

`define TCM_RESP_OKAY 2'h0
`define TCM_RESP_SLVERR 2'h2

`endif

// File: common/tcm_pkg.sv
// types shared by the readout block modules
`include "tcm_map.svh"
package tcm_pkg;

   typedef enum logic [0:0] {
      WR_IDLE = 1'b0,
      WR_RESP = 1'b1
   } tcm_wr_e;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } tcm_rd_e;

   typedef struct packed {
      logic [`TCM_NCH-1:0][15:0] value;
      logic [`TCM_NCH-1:0] neg;
      logic [`TCM_NCH-1:0] open;
      logic [`TCM_NCH-1:0] open_rise;
   } tcm_store_s;

endpackage

// File: common/tcm_store_if.sv
// conversion results in, formatted selected channel out
`timescale 1ns/1ps
interface tcm_store_if;
   logic conv_valid;
   logic [2:0] conv_chan;
   logic [15:0] conv_value;
   logic conv_neg;
   logic [7:0] conv_open;
   logic [2:0] sel_chan;
   logic fmt_twos;
   logic fmt_unip;
   logic [15:0] sel_word;
   logic [7:0] open_flags;
   logic [7:0] open_rise;

   modport top (output conv_valid, conv_chan, conv_value, conv_neg,
      conv_open, sel_chan, fmt_twos, fmt_unip,
      input sel_word, open_flags, open_rise);
   modport store (input conv_valid, conv_chan, conv_value, conv_neg,
      conv_open, sel_chan, fmt_twos, fmt_unip,
      output sel_word, open_flags, open_rise);
endinterface

// File: rtl/tcm_chan_store.sv
// per-channel result memory and output word formatting
`timescale 1ns/1ps
`include "tcm_map.svh"
module tcm_chan_store (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   tcm_store_if.store sif
);

   tcm_pkg::tcm_store_s s_ff;
   tcm_pkg::tcm_store_s nxt_s;

   function automatic logic [15:0] fmt_word(
      logic [15:0] v,
      logic neg,
      logic twos,
      logic unip
   );
      logic [15:0] mag;
      mag = {1'b0, v[14:0]};
      if (unip) begin
         fmt_word = v;
      end else if (twos && neg) begin
         fmt_word = 16'h0000 - mag;
      end else begin
         fmt_word = {neg, v[14:0]};
      end
   endfunction

   always_comb begin
      nxt_s = s_ff;
      // converter runs on its own pace; the scan only picks results up
      if (sif.conv_valid) begin
         nxt_s.value[sif.conv_chan] = sif.conv_value;
         nxt_s.neg[sif.conv_chan] = sif.conv_neg;
      end
      nxt_s.open = sif.conv_open;
      nxt_s.open_rise = sif.conv_open & ~s_ff.open;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   assign sif.sel_word = fmt_word(s_ff.value[sif.sel_chan],
      s_ff.neg[sif.sel_chan], sif.fmt_twos, sif.fmt_unip);
   assign sif.open_flags = s_ff.open;
   assign sif.open_rise = s_ff.open_rise;

endmodule

// File: verification/tcm_readout_checker.sv
// port assertions for the thermocouple readout block
`timescale 1ns/1ps
module tcm_readout_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic scan_strobe,
   input wire logic [7:0] conv_open,
   input wire logic [15:0] data_word,
   input wire logic [15:0] status_word,
   input wire logic sign_flag_input,
   input wire logic [2:0] channel_index_inputs,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_sign;
      sign_flag_input == data_word[15];
   endproperty
   a_sign: assert property (p_sign) else $error("sign point wrong");

   property p_index;
      channel_index_inputs == status_word[2:0];
   endproperty
   a_index: assert property (p_index) else $error("index wrong");

   property p_unused;
      status_word[7:3] == 5'h00;
   endproperty
   a_unused: assert property (p_unused) else $error("unused set");

   // words only move three cycles after a synchronised pin rise
   property p_scan_only;
      ($changed(data_word) || $changed(channel_index_inputs)) |->
         $past(scan_strobe, 3) && !$past(scan_strobe, 4);
   endproperty
   a_scan_only: assert property (p_scan_only) else $error("no scan");

   property p_settle;
      $changed(channel_index_inputs) |=> $stable(channel_index_inputs)[*3];
   endproperty
   a_settle: assert property (p_settle) else $error("index moved");

   // flags reload only with a scan, from the store's copy two edges old
   property p_open;
      $changed(status_word) |-> status_word[15:8] == $past(conv_open, 2);
   endproperty
   a_open: assert property (p_open) else $error("open flags wrong");

   property p_rvalid;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer late");

   property p_bdone;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write answer held");
endmodule

bind tcm_readout_top tcm_readout_checker i_chk (.aclk, .aresetn,
   .scan_strobe, .conv_open, .data_word, .status_word, .sign_flag_input,
   .channel_index_inputs, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_bvalid, .s_axi_bready);

// File: verification/tcm_cpu_model.sv
// controller model: scan pin, word sampling, demultiplex by index
`timescale 1ns/1ps
module tcm_cpu_model (
   input wire logic aclk,
   output logic scan_strobe,
   input wire logic [15:0] data_word,
   input wire logic [15:0] status_word
);
   localparam logic [2:0] index_mask_constant = 3'h7;
   logic [15:0] mem [8];
   initial scan_strobe = 1'h0;
   // both levels held two cycles or more, so the synchroniser sees each
   task automatic scan(input int slow);
      @(posedge aclk);
      scan_strobe <= 1'h1;
      repeat (2 + slow) @(posedge aclk);
      scan_strobe <= 1'h0;
      repeat (3 + slow) @(posedge aclk);
      @(negedge aclk);
      mem[status_word[2:0] & index_mask_constant] = data_word;
   endtask
endmodule

// File: verification/tb_thermocouple_channel_mux_readout.sv
// self-checking bench: register tasks, controller scans, word checks
`timescale 1ns/1ps
module tb_thermocouple_channel_mux_readout;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic ce = 1'h1;
   logic conv_valid = 1'h0;
   logic conv_neg = 1'h0;
   logic [2:0] conv_chan = 3'h0;
   logic [15:0] conv_value = 16'h0000;
   logic [7:0] conv_open = 8'h00;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic [15:0] data_word, status_word;
   logic [2:0] channel_index_inputs;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic scan_strobe, sign_flag_input, irq, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] cfg = 2'h0;
   int num_errors = 0;
   int n_checks = 0;
   int cnt = 0;

   always #5 aclk = ~aclk;

   tcm_readout_top i_dut (.aclk, .aresetn, .ce, .scan_strobe, .conv_valid,
      .conv_chan, .conv_value, .conv_neg, .conv_open, .data_word,
      .status_word, .sign_flag_input, .channel_index_inputs, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   tcm_cpu_model i_cpu (.aclk, .scan_strobe, .data_word, .status_word);

   function automatic logic [15:0] val(input logic [2:0] n);
      return {1'h1, n, 12'h0a5};
   endfunction

   // top input bit is set on purpose: signed modes must drop it
   function automatic logic [15:0] fmt(input logic [2:0] n);
      logic [15:0] v;
      v = val(n);
      if (cfg[1]) return v;
      if (cfg[0] && n[0]) return 16'h0000 - {1'h0, v[14:0]};
      return {n[0], v[14:0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic results();
      if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      bit ad;
      bit wd;
      ad = 1'h0;
      wd = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         ad |= s_axi_awready;
         wd |= s_axi_wready;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!(ad && wd));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", er, s_axi_bresp);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask

   task automatic cv(input logic [2:0] n);
      @(posedge aclk);
      conv_valid <= 1'h1;
      conv_chan <= n;
      conv_value <= val(n);
      conv_neg <= n[0];
      @(posedge aclk);
      conv_valid <= 1'h0;
   endtask

   task automatic sc(input logic [2:0] ix, input int slow);
      i_cpu.scan(slow);
      cnt++;
      chk("data", fmt(ix), data_word);
      chk("status", {conv_open, 5'h00, ix}, status_word);
      chk("stored", fmt(ix), i_cpu.mem[ix]);
   endtask

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         rd(8'(4 * i), i ? 32'h0 : 32'h0000_00ff, 2'h0);
      end
      rd(8'h18, 32'h0, 2'h2);
      wr(8'h18, 32'h0000_0001, 2'h2);
      for (int i = 0; i < 8; i++) cv(3'(i));
      wr(8'h0c, 32'h0000_0100, 2'h0);
      for (int i = 0; i < 9; i++) sc(3'(i), i % 2);
      chk("irq", 32'h1, irq);
      rd(8'h08, 32'h0000_0100, 2'h0);
      wr(8'h08, 32'h0000_0100, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      chk("irq", 32'h0, irq);
      rd(8'h10, {16'h0000, fmt(3'h0)}, 2'h0);
      wr(8'h00, 32'h0000_0024, 2'h0);
      sc(3'h2, 0);
      sc(3'h5, 0);
      sc(3'h2, 0);
      wr(8'h00, 32'h0000_0010, 2'h0);
      sc(3'h4, 0);
      sc(3'h4, 1);
      wr(8'h00, 32'h0000_0002, 2'h0);
      for (int i = 1; i < 4; i++) begin
         cfg = 2'(i);
         wr(8'h04, 32'(i), 2'h0);
         sc(3'h1, 0);
      end
      wr(8'h00, 32'h0, 2'h0);
      i_cpu.scan(0);
      chk("held", fmt(3'h1), data_word);
      rd(8'h14, 32'(cnt), 2'h0);
      wr(8'h0c, 32'h0, 2'h0);
      wr(8'h08, 32'h0000_01ff, 2'h0);
      conv_open <= 8'hff;
      repeat (4) @(posedge aclk);
      rd(8'h08, 32'h0000_00ff, 2'h0);
      chk("irq", 32'h0, irq);
      wr(8'h0c, 32'h0000_0080, 2'h0);
      rd(8'h0c, 32'h0000_0080, 2'h0);
      chk("irq", 32'h1, irq);
      wr(8'h08, 32'h0000_00ff, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      chk("irq", 32'h0, irq);
      wr(8'h00, 32'h0000_0080, 2'h0);
      sc(3'h7, 1);
      // a scan while the enable is low must leave no trace
      @(posedge aclk);
      ce <= 1'h0;
      i_cpu.scan(0);
      @(posedge aclk);
      ce <= 1'h1;
      rd(8'h14, 32'(cnt), 2'h0);
      results();
   end

   // a full run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      results();
   end
endmodule
